// ### fslr_regs.svh
`ifndef FSLR_REGS_SVH
`define FSLR_REGS_SVH

// =========================================
// register byte offsets
`define FSLR_MAX_FREQ      8'h00
`define FSLR_UL_SRC        8'h04
`define FSLR_UL_DIG        8'h08
`define FSLR_UL_OFS        8'h0c
`define FSLR_LL_FREQ       8'h10
`define FSLR_LL_ACT        8'h14
`define FSLR_RAMP_BASE     8'h18
`define FSLR_BIAS          8'h38
`define FSLR_MODE          8'h3c
`define FSLR_PRESET        8'h40
`define FSLR_BIND          8'h44
`define FSLR_SRC_SEL       8'h48
`define FSLR_STAT_OUT      8'h4c
`define FSLR_STAT_SET      8'h50
// =========================================
// mode register fields
`define FSLR_MODE_RES_LSB  0
`define FSLR_MODE_MEM_BIT  2
`define FSLR_MODE_REF_LSB  3
`define FSLR_MODE_UPD_BIT  5
`define FSLR_MODE_DIR_BIT  6
`define FSLR_MODE_INIT_BIT 7
// =========================================
// reset values, frequencies in 0.01Hz
`define FSLR_MAX_FREQ_RST  16'h1388
`define FSLR_UL_DIG_RST    16'h1388
`define FSLR_PRESET_RST    16'h1388
`define FSLR_RAMP_RST      16'h000a
`define FSLR_MODE_RST      16'h0006
`define FSLR_FIXED_REF     16'h2710
`define FSLR_FULL_PCT      16'h2710
`define FSLR_TICK_HZ       1000
`endif

// ### fslr_pkg.sv
package fslr_pkg;
   typedef logic [15:0] fslr_freq_t;
   typedef logic [15:0] fslr_pct_t;
   typedef enum logic [1:0] {FSLR_CH_PANEL, FSLR_CH_TERM, FSLR_CH_COMM} fslr_chan_e;
endpackage

// ### fslr_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fslr_regs.svh"
module fslr_top
#(
   parameter int TICK_HZ = `FSLR_TICK_HZ
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire fslr_pkg::fslr_pct_t analog_input_one,
   input  wire fslr_pkg::fslr_pct_t analog_input_two,
   input  wire fslr_pkg::fslr_pct_t analog_input_three,
   input  wire fslr_pkg::fslr_pct_t pulse_input_terminal,
   input  wire fslr_pkg::fslr_pct_t multistep_percent,
   input  wire logic signed [15:0] comm_percent,
   input  wire fslr_pkg::fslr_chan_e cmd_channel,
   input  wire logic [1:0]        accel_group,
   input  wire logic              run_cmd,
   input  wire logic              up_pulse,
   input  wire logic              down_pulse,
   input  wire logic              tick,
   output fslr_pkg::fslr_freq_t   output_frequency,
   output fslr_pkg::fslr_freq_t   set_frequency,
   output logic                   running,
   output logic                   direction
);
   import fslr_pkg::*;

   // =========================================
   // configuration storage
   fslr_freq_t  max_output_frequency;
   logic [2:0]  upper_limit_source;
   fslr_freq_t  upper_limit_digital;
   fslr_freq_t  upper_limit_offset;
   fslr_freq_t  lower_limit_frequency;
   logic [1:0]  below_lower_limit_action;
   logic [15:0] ramp_time [8];
   fslr_freq_t  combination_bias_frequency;
   logic [15:0] mode;
   fslr_freq_t  preset_frequency;
   logic [11:0] command_source_binding;
   logic [11:0] source_sel;
   fslr_freq_t  dig_sp;
   fslr_freq_t  target;
   logic        run_q;
   logic [15:0] phase;

   logic        aw_full;
   logic        w_full;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        do_write;
   logic        hit;
   logic [31:0] rd_mux;
   logic        rd_hit;

   logic [1:0]  frequency_resolution;
   logic        stop_memory_select;
   logic [1:0]  ramp_reference_select;
   logic        updown_base_select;
   logic        param_init;
   assign frequency_resolution  = mode[`FSLR_MODE_RES_LSB +: 2];
   assign stop_memory_select    = mode[`FSLR_MODE_MEM_BIT];
   assign ramp_reference_select = mode[`FSLR_MODE_REF_LSB +: 2];
   assign updown_base_select    = mode[`FSLR_MODE_UPD_BIT];
   assign param_init = ce && do_write && aw_addr_q == `FSLR_MODE && w_strb_q[0]
                       && w_data_q[`FSLR_MODE_INIT_BIT];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // percent in 0.01% units to frequency
   function automatic fslr_freq_t pct_freq(input fslr_pct_t p, input fslr_freq_t fm);
      logic [31:0] prod;
      prod = 32'(p) * 32'(fm);
      pct_freq = 16'(prod / 32'(`FSLR_FULL_PCT));
   endfunction

   // =========================================
   // axi write channel
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end
      else if (ce)
      begin
         s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= hit ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end

   always_comb
   begin
      hit = 1'b1;
      if (aw_addr_q[1:0] != 2'b00)
         hit = 1'b0;
      else if (aw_addr_q > `FSLR_SRC_SEL)
         hit = 1'b0;
   end

   // =========================================
   // configuration writes
   always_ff @(posedge aclk)
      if (!aresetn || param_init)
      begin
         max_output_frequency       <= `FSLR_MAX_FREQ_RST;
         upper_limit_source         <= 3'h0;
         upper_limit_digital        <= `FSLR_UL_DIG_RST;
         upper_limit_offset         <= 16'h0;
         lower_limit_frequency      <= 16'h0;
         below_lower_limit_action   <= 2'h0;
         combination_bias_frequency <= 16'h0;
         mode                       <= `FSLR_MODE_RST;
         preset_frequency           <= `FSLR_PRESET_RST;
         command_source_binding     <= 12'h000;
         source_sel                 <= 12'h000;
         for (int i = 0; i < 8; i++)
            ramp_time[i] <= `FSLR_RAMP_RST;
      end
      else if (ce && do_write)
      begin
         if (aw_addr_q == `FSLR_MAX_FREQ)
            max_output_frequency <= merge(max_output_frequency, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_UL_SRC && w_strb_q[0] && w_data_q[2:0] <= 3'h5)
            upper_limit_source <= w_data_q[2:0];
         else if (aw_addr_q == `FSLR_UL_DIG)
            upper_limit_digital <= merge(upper_limit_digital, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_UL_OFS)
            upper_limit_offset <= merge(upper_limit_offset, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_LL_FREQ &&
                  merge(lower_limit_frequency, w_data_q, w_strb_q) <= upper_limit_digital)
            lower_limit_frequency <= merge(lower_limit_frequency, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_LL_ACT && w_strb_q[0])
            below_lower_limit_action <= w_data_q[1:0];
         else if (aw_addr_q >= `FSLR_RAMP_BASE && aw_addr_q < `FSLR_BIAS)
            ramp_time[3'(aw_addr_q[7:2] - 6'h06)] <=
               merge(ramp_time[3'(aw_addr_q[7:2] - 6'h06)], w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_BIAS)
            combination_bias_frequency <= merge(combination_bias_frequency, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_MODE)
            mode <= {9'h0, 7'(merge(mode, w_data_q, w_strb_q))};
         else if (aw_addr_q == `FSLR_PRESET)
            preset_frequency <= merge(preset_frequency, w_data_q, w_strb_q);
         else if (aw_addr_q == `FSLR_BIND)
            command_source_binding <= 12'(merge({4'h0, command_source_binding}, w_data_q,
                                                w_strb_q));
         else if (aw_addr_q == `FSLR_SRC_SEL)
            source_sel <= 12'(merge({4'h0, source_sel}, w_data_q, w_strb_q));
      end

   // =========================================
   // axi read channel
   always_comb
   begin
      rd_mux = 32'h0;
      rd_hit = (s_axi_araddr[1:0] == 2'b00);
      if (s_axi_araddr == `FSLR_MAX_FREQ)
         rd_mux = {16'h0, max_output_frequency};
      else if (s_axi_araddr == `FSLR_UL_SRC)
         rd_mux = {29'h0, upper_limit_source};
      else if (s_axi_araddr == `FSLR_UL_DIG)
         rd_mux = {16'h0, upper_limit_digital};
      else if (s_axi_araddr == `FSLR_UL_OFS)
         rd_mux = {16'h0, upper_limit_offset};
      else if (s_axi_araddr == `FSLR_LL_FREQ)
         rd_mux = {16'h0, lower_limit_frequency};
      else if (s_axi_araddr == `FSLR_LL_ACT)
         rd_mux = {30'h0, below_lower_limit_action};
      else if (s_axi_araddr >= `FSLR_RAMP_BASE && s_axi_araddr < `FSLR_BIAS)
         rd_mux = {16'h0, ramp_time[3'(s_axi_araddr[7:2] - 6'h06)]};
      else if (s_axi_araddr == `FSLR_BIAS)
         rd_mux = {16'h0, combination_bias_frequency};
      else if (s_axi_araddr == `FSLR_MODE)
         rd_mux = {16'h0, mode};
      else if (s_axi_araddr == `FSLR_PRESET)
         rd_mux = {16'h0, preset_frequency};
      else if (s_axi_araddr == `FSLR_BIND)
         rd_mux = {20'h0, command_source_binding};
      else if (s_axi_araddr == `FSLR_SRC_SEL)
         rd_mux = {20'h0, source_sel};
      else if (s_axi_araddr == `FSLR_STAT_OUT)
         rd_mux = {15'h0, running, output_frequency};
      else if (s_axi_araddr == `FSLR_STAT_SET)
         rd_mux = {16'h0, set_frequency};
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'b00;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_hit ? rd_mux : 32'h0;
            s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
      end

   // =========================================
   // source values and setpoint path
   fslr_freq_t comm_freq;
   fslr_freq_t upper_limit;
   fslr_freq_t src_a;
   fslr_freq_t src_b;
   fslr_freq_t quant_sp;
   logic [3:0] bind_code;
   logic [17:0] sum;
   logic [15:0] comm_mag;

   // sign carries no direction here; magnitude only, saturated at full scale
   assign comm_mag  = comm_percent[15] ? 16'(-comm_percent) : comm_percent;
   assign comm_freq = pct_freq(comm_mag > `FSLR_FULL_PCT ? `FSLR_FULL_PCT : comm_mag,
                               max_output_frequency);
   assign bind_code = command_source_binding[4 * cmd_channel +: 4];

   function automatic fslr_freq_t src_val(input logic [3:0] code);
      src_val = 16'h0; // unsupported sources contribute nothing
      if (code == 4'h0 || code == 4'h1)
         src_val = dig_sp;
      else if (code == 4'h2)
         src_val = pct_freq(analog_input_one, max_output_frequency);
      else if (code == 4'h3)
         src_val = pct_freq(analog_input_two, max_output_frequency);
      else if (code == 4'h4)
         src_val = pct_freq(analog_input_three, max_output_frequency);
      else if (code == 4'h5)
         src_val = pct_freq(pulse_input_terminal, max_output_frequency);
      else if (code == 4'h6)
         src_val = pct_freq(multistep_percent, max_output_frequency);
      else if (code == 4'h9)
         src_val = comm_freq;
   endfunction

   always_comb
   begin
      // offset only for analog and pulse sources
      sum = 18'h0;
      if (upper_limit_source == 3'h0)
         sum = {2'b00, upper_limit_digital};
      else if (upper_limit_source == 3'h1)
         sum = 18'(pct_freq(analog_input_one, max_output_frequency)) + 18'(upper_limit_offset);
      else if (upper_limit_source == 3'h2)
         sum = 18'(pct_freq(analog_input_two, max_output_frequency)) + 18'(upper_limit_offset);
      else if (upper_limit_source == 3'h3)
         sum = 18'(pct_freq(analog_input_three, max_output_frequency))
               + 18'(upper_limit_offset);
      else if (upper_limit_source == 3'h4)
         sum = 18'(pct_freq(pulse_input_terminal, max_output_frequency))
               + 18'(upper_limit_offset);
      else
         sum = {2'b00, comm_freq};
      upper_limit = sum > 18'(max_output_frequency) ? max_output_frequency : sum[15:0];
      // a bound channel overrides main, aux and combination
      src_a = src_val(bind_code != 4'h0 ? bind_code : source_sel[3:0]);
      src_b = src_val(source_sel[11:8]);
      if (bind_code == 4'h0 && source_sel[7:4] == 4'h1)
         sum = 18'(src_a) + 18'(src_b) + 18'(combination_bias_frequency);
      else
         sum = {2'b00, src_a};
      if (sum > 18'(upper_limit))
         sum = 18'(upper_limit);
      // coarse resolution drops the hundredths digit
      quant_sp = frequency_resolution == 2'h1 ? 16'(sum[15:0] - sum[15:0] % 16'd10)
                                              : sum[15:0];
   end

   // =========================================
   // lower limit handling and run state
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         target        <= 16'h0;
         set_frequency <= 16'h0;
         running       <= 1'b0;
         run_q         <= 1'b0;
         direction     <= 1'b0;
      end
      else if (ce)
      begin
         run_q         <= run_cmd;
         set_frequency <= quant_sp;
         direction     <= mode[`FSLR_MODE_DIR_BIT];
         running       <= run_cmd && !(quant_sp < lower_limit_frequency &&
                                       below_lower_limit_action == 2'h0);
         if (!run_cmd)
            target <= 16'h0;
         else if (quant_sp >= lower_limit_frequency)
            target <= quant_sp;
         else if (below_lower_limit_action == 2'h1)
            target <= lower_limit_frequency;
         else
            target <= 16'h0;
      end

   // =========================================
   // digital setpoint with up/down and stop memory
   fslr_freq_t step_sz;
   fslr_freq_t ud_base;
   assign step_sz = frequency_resolution == 2'h1 ? 16'h000a : 16'h0001;
   assign ud_base = updown_base_select ? dig_sp : output_frequency;

   always_ff @(posedge aclk)
      if (!aresetn || param_init)
         dig_sp <= `FSLR_PRESET_RST;
      else if (ce)
      begin
         if (run_q && !run_cmd && !stop_memory_select)
            dig_sp <= preset_frequency;
         else if (run_q && !run_cmd)
            dig_sp <= dig_sp;
         else if (up_pulse && !down_pulse)
            dig_sp <= 17'(ud_base) + 17'(step_sz) > 17'(max_output_frequency)
                      ? max_output_frequency : 16'(ud_base + step_sz);
         else if (down_pulse && !up_pulse)
            dig_sp <= ud_base < step_sz ? 16'h0 : 16'(ud_base - step_sz);
      end

   // =========================================
   // linear ramp; phase holds a 16-bit fraction of 0.01Hz
   fslr_freq_t  ramp_ref;
   logic [15:0] t_sel;
   logic [31:0] step_q;
   logic [31:0] adv;
   logic        accel;
   assign accel    = output_frequency < target;
   assign ramp_ref = ramp_reference_select == 2'h0 ? max_output_frequency :
                     ramp_reference_select == 2'h1 ? set_frequency : `FSLR_FIXED_REF;
   assign t_sel    = ramp_time[{accel_group, !accel}];
   // one divider; a slow but small datapath, good for ms-scale ticks
   assign step_q   = ({16'h0, ramp_ref} << 16) / (32'(t_sel) * 32'(TICK_HZ));
   assign adv      = 32'(phase) + step_q;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         output_frequency <= 16'h0;
         phase            <= 16'h0;
      end
      else if (ce && tick)
      begin
         // zero time divides by zero; keep the fraction clean for later ramps
         phase <= t_sel == 16'h0 ? 16'h0 : adv[15:0];
         if (t_sel == 16'h0 || output_frequency == target)
            output_frequency <= target;
         else if (accel)
            output_frequency <= 32'(output_frequency) + adv[31:16] > 32'(target)
                                ? target : 16'(output_frequency + adv[31:16]);
         else
            output_frequency <= 32'(output_frequency) < adv[31:16] + 32'(target)
                                ? target : 16'(output_frequency - adv[31:16]);
      end

   // =========================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_upper;
      ce && run_cmd |=> set_frequency <= $past(max_output_frequency);
   endproperty
   a_upper: assert property (p_upper) else $error("setpoint above maximum");

   property p_lower_ok;
      ce && do_write && aw_addr_q == `FSLR_LL_FREQ
      && merge(lower_limit_frequency, w_data_q, w_strb_q) > upper_limit_digital
      |=> $stable(lower_limit_frequency);
   endproperty
   a_lower_ok: assert property (p_lower_ok) else $error("lower limit exceeds upper");

   property p_res;
      ce && frequency_resolution == 2'h1 |=> set_frequency % 16'd10 == 16'h0;
   endproperty
   a_res: assert property (p_res) else $error("resolution not applied");

   property p_nomem;
      ce && run_q && !run_cmd && !stop_memory_select && !param_init
      |=> dig_sp == $past(preset_frequency);
   endproperty
   a_nomem: assert property (p_nomem) else $error("preset not restored");

   property p_mem;
      ce && run_q && !run_cmd && stop_memory_select && !param_init |=> $stable(dig_sp);
   endproperty
   a_mem: assert property (p_mem) else $error("stop memory lost");

   property p_stop;
      ce && run_cmd && quant_sp < lower_limit_frequency && below_lower_limit_action == 2'h0
      |=> !running && target == 16'h0;
   endproperty
   a_stop: assert property (p_stop) else $error("below lower limit did not stop");

   property p_init;
      ce && param_init ##1 ce |=> !direction;
   endproperty
   a_init: assert property (p_init) else $error("direction not restored");

   property p_ramp;
      ce && tick && accel && t_sel != 16'h0
      |=> output_frequency >= $past(output_frequency) && output_frequency <= $past(target);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp overshoot");

   c_bvalid: cover property (s_axi_bvalid && s_axi_bready);
   c_reach:  cover property (ce && tick && output_frequency != target ##1 output_frequency == target);
   c_bound:  cover property (bind_code != 4'h0 && run_cmd);
   c_stop:   cover property (run_q && !run_cmd);
endmodule

// ### fslr_drive_model.sv
`timescale 1ns/1ps
// ========================================
// command side: tick source and terminals
module fslr_drive_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] group_req,
   output logic            tick,
   output logic [1:0]      accel_group
);
   logic [1:0] div;
   // tick every four clocks, far faster than real to keep runs short
   always_ff @(posedge aclk)
   begin
      div  <= aresetn ? div + 2'h1 : 2'h0;
      tick <= aresetn & (div == 2'h3);
   end
   // terminals select the time pair
   always_ff @(posedge aclk)
      accel_group <= group_req;
endmodule

// ### tb.sv
`timescale 1ns/1ps
`include "fslr_regs.svh"
module tb;
   import fslr_pkg::*;
   // ========================================
   // stimulus and observed signals
   logic aclk = 0, aresetn = 0, run_cmd = 0, up_pulse = 0, down_pulse = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, tick, running, direction;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, grp = 2'h0, accel_group;
   fslr_pct_t analog_input_one = 0, analog_input_two = 0, analog_input_three = 0;
   fslr_pct_t pulse_input_terminal = 0, multistep_percent = 0;
   logic signed [15:0] comm_percent = 0;
   fslr_chan_e cmd_channel = FSLR_CH_PANEL;
   fslr_freq_t output_frequency, set_frequency;
   int fails = 0, compares = 0;
   initial forever #2 aclk = ~aclk;
   fslr_top #(.TICK_HZ(4)) uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_input_one, .analog_input_two,
      .analog_input_three, .pulse_input_terminal, .multistep_percent, .comm_percent, .cmd_channel,
      .accel_group, .run_cmd, .up_pulse, .down_pulse, .tick, .output_frequency, .set_frequency,
      .running, .direction);
   fslr_drive_model partner (.aclk, .aresetn, .group_req(grp), .tick, .accel_group);
   // ========================================
   // bus tasks and checks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rd_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd_v = s_axi_rdata; rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // bounded wait, since ramp ticks come from the partner
   task automatic wait_out(input fslr_freq_t e);
      int n;
      n = 0;
      while (output_frequency !== e && n < 400)
      begin
         @(posedge aclk);
         n++;
      end
      chk({16'h0, output_frequency}, {16'h0, e});
   endtask
   // ========================================
   // scenarios
   task automatic t_defaults();
      rd(`FSLR_MAX_FREQ); chk(rd_v, 32'h1388);
      rd(`FSLR_MODE); chk(rd_v, 32'h6);
      rd(8'h80); chk({30'h0, rd_r}, 32'h2);
      wr(8'h80, 32'h0); chk({30'h0, rd_r}, 32'h2);
   endtask
   task automatic t_lower();
      wr(`FSLR_LL_FREQ, 32'h1770); rd(`FSLR_LL_FREQ); chk(rd_v, 32'h0);
      wr(`FSLR_LL_FREQ, 32'h3e8); rd(`FSLR_LL_FREQ); chk(rd_v, 32'h3e8);
   endtask
   task automatic t_run_limit();
      wr(`FSLR_RAMP_BASE, 32'h0); wr(8'h1c, 32'h0);
      @(posedge aclk);
      run_cmd <= 1'b1;
      wait_out(16'h1388);
      wr(`FSLR_UL_DIG, 32'h0bb8);
      wait_out(16'h0bb8);
      chk({16'h0, set_frequency}, 32'h0bb8);
   endtask
   task automatic t_upper_src();
      wr(`FSLR_UL_DIG, 32'h1388); wr(`FSLR_UL_OFS, 32'h64);
      @(posedge aclk);
      analog_input_one <= 16'h1388;
      wr(`FSLR_UL_SRC, 32'h1);
      wait_out(16'h0a28);
      wr(`FSLR_UL_SRC, 32'h6); rd(`FSLR_UL_SRC); chk(rd_v, 32'h1);
      @(posedge aclk);
      run_cmd <= 1'b0;
      wait_out(16'h0);
   endtask
   task automatic t_init();
      wr(`FSLR_MODE, 32'h46);
      @(posedge aclk);
      chk({31'h0, direction}, 32'h1);
      wr(`FSLR_MODE, 32'h80);
      @(posedge aclk);
      chk({31'h0, direction}, 32'h0);
      rd(`FSLR_UL_SRC); chk(rd_v, 32'h0);
   endtask
   task automatic pulse(input logic up);
      @(posedge aclk);
      up_pulse <= up;
      down_pulse <= !up;
      @(posedge aclk);
      up_pulse <= 1'b0;
      down_pulse <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic run_stop();
      @(posedge aclk);
      run_cmd <= 1'b1;
      @(posedge aclk);
      run_cmd <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic t_ramp();
      grp <= 2'h1;
      wr(8'h20, 32'h2); wr(8'h24, 32'h2);
      @(posedge aclk);
      run_cmd <= 1'b1;
      @(posedge aclk iff output_frequency != 16'h0);
      chk({16'h0, output_frequency}, 32'h0271);
      wait_out(16'h1388);
      wr(`FSLR_MODE, 32'h16);
      @(posedge aclk);
      run_cmd <= 1'b0;
      @(posedge aclk iff output_frequency != 16'h1388);
      chk({16'h0, output_frequency}, 32'h0ea6);
      wait_out(16'h0);
      grp <= 2'h0;
   endtask
   task automatic t_setpt();
      wr(`FSLR_MODE, 32'h26); pulse(1'b0);
      chk({16'h0, set_frequency}, 32'h1387);
      wr(`FSLR_MODE, 32'h25); repeat (2) @(posedge aclk);
      chk({16'h0, set_frequency}, 32'h137e);
      wr(`FSLR_MODE, 32'h06); pulse(1'b1);
      chk({16'h0, set_frequency}, 32'h1);
      run_stop(); chk({16'h0, set_frequency}, 32'h1);
      wr(`FSLR_MODE, 32'h02); run_stop();
      chk({16'h0, set_frequency}, 32'h1388);
   endtask
   task automatic t_source();
      wr(`FSLR_LL_FREQ, 32'h3e8); wr(`FSLR_LL_ACT, 32'h1); wr(`FSLR_SRC_SEL, 32'h9);
      comm_percent <= 16'hfc18; // minus ten percent
      run_cmd <= 1'b1;
      wait_out(16'h03e8);
      chk({16'h0, set_frequency}, 32'h01f4);
      wr(`FSLR_LL_ACT, 32'h0);
      @(posedge aclk);
      chk({31'h0, running}, 32'h0);
      wait_out(16'h0);
      wr(`FSLR_LL_ACT, 32'h2);
      @(posedge aclk);
      chk({31'h0, running}, 32'h1);
      wr(`FSLR_BIAS, 32'h64); wr(`FSLR_SRC_SEL, 32'h219);
      @(posedge aclk);
      chk({16'h0, set_frequency}, 32'h0c1c);
      wr(`FSLR_BIND, 32'h22);
      @(posedge aclk);
      chk({16'h0, set_frequency}, 32'h09c4);
      cmd_channel <= FSLR_CH_TERM;
      repeat (2) @(posedge aclk);
      chk({16'h0, set_frequency}, 32'h09c4);
      run_cmd <= 1'b0;
   endtask
   task automatic stop_test();
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_defaults();
      t_lower();
      t_run_limit();
      t_upper_src();
      t_init();
      t_ramp();
      t_setpt();
      t_source();
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      fails++;
      stop_test();
   end
endmodule
